// ===== core/spr_pkg.sv
// Constants shared by the serial pin and interrupt router.
package spr_pkg;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    localparam int SPR_ADDR_W = 12;
    localparam int SPR_DATA_W = 8;
    localparam logic [11:0] SPR_SWAP_ADDR = 12'hf57;
    localparam logic [11:0] SPR_SEL_ADDR = 12'hfcb;
    localparam logic [11:0] SPR_OWN_LO_ADDR = 12'hf59;
    localparam logic [11:0] SPR_OWN_HI_ADDR = 12'hf5a;
    localparam logic [7:0] SPR_SWAP_RESET = 8'h00;
    localparam logic [7:0] SPR_SEL_RESET = 8'h00;
    localparam logic [7:0] SPR_SWAP_MASK = 8'h03;
    localparam logic [7:0] SPR_SEL_MASK = 8'h13;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SPR_U0_SWAP_BIT = 0;
    localparam int SPR_U1_SWAP_BIT = 1;
    localparam int SPR_SEL_LSB = 0;
    localparam int SPR_BANK_BIT = 4;

    // Serial-select codes.
    localparam logic [1:0] SPR_SEL_UART_I2C = 2'h0;
    localparam logic [1:0] SPR_SEL_UART_SIO = 2'h1;
    localparam logic [1:0] SPR_SEL_SIO_I2C = 2'h2;

    // ------------------------------------------------------------------
    // Pin indices of the routing set
    // ------------------------------------------------------------------
    localparam int SPR_NPINS = 11;
    localparam logic [3:0] SPR_P20 = 4'h0;
    localparam logic [3:0] SPR_P21 = 4'h1;
    localparam logic [3:0] SPR_P22 = 4'h2;
    localparam logic [3:0] SPR_P23 = 4'h3;
    localparam logic [3:0] SPR_P24 = 4'h4;
    localparam logic [3:0] SPR_P25 = 4'h5;
    localparam logic [3:0] SPR_PB4 = 4'h6;
    localparam logic [3:0] SPR_PB5 = 4'h7;
    localparam logic [3:0] SPR_PB6 = 4'h8;
    localparam logic [3:0] SPR_P90 = 4'h9;
    localparam logic [3:0] SPR_P91 = 4'ha;
    localparam int SPR_LO_PINS = 8;

endpackage : spr_pkg

// ===== core/spr_pin_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
module spr_pin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    logic s1_reg; // First stage, read only by the second.
    logic s2_reg; // Second stage.
    logic s3_reg; // Third stage.
    logic out_reg; // Filtered level.

    // The level is taken once the second and third stages agree.
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
            out_reg <= RESET_VAL;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                out_reg <= s3_reg;
            end
        end
    end

    assign sync_out = out_reg;

endmodule : spr_pin_sync

// ===== core/spr_router.sv
// Serial pin and interrupt router: pin routing, slot routing and registers.
//
// Summary of operation
// - UART1 swap bit exchanges P91/P90 receive and transmit.
// - UART0 on P20/P21 or PB4/PB5, swappable.
// - Unassigned pins serve as general port pins.
// - Select code picks two controllers; 11 reserved.
// - Interrupt sources map onto slots 7, 6, 15.
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
module spr_router
    import spr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [SPR_ADDR_W-1:0] reg_addr,
    input wire logic [SPR_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [SPR_DATA_W-1:0] reg_rdata,
    input wire logic [SPR_NPINS-1:0] pin_in,
    output logic [SPR_NPINS-1:0] pin_out,
    output logic [SPR_NPINS-1:0] pin_oe,
    input wire logic [SPR_NPINS-1:0] gpio_out,
    input wire logic [SPR_NPINS-1:0] gpio_oe,
    input wire logic [SPR_NPINS-1:0] pin_function_control,
    output logic [SPR_NPINS-1:0] gpio_in,
    output logic [SPR_NPINS-1:0] pin_owned,
    input wire logic uart0_transmit,
    output logic uart0_receive,
    input wire logic uart1_transmit,
    output logic uart1_receive,
    input wire logic sync_serial_out,
    output logic sync_serial_in,
    input wire logic sync_serial_clock,
    input wire logic i2c_sda_pull_low,
    input wire logic i2c_scl_pull_low,
    output logic i2c_data_line,
    output logic i2c_clock_line,
    input wire logic uart0_tx_interrupt,
    input wire logic uart0_rx_interrupt,
    input wire logic sync_serial_interrupt,
    input wire logic i2c_interrupt,
    output logic irq_slot7,
    output logic irq_slot6,
    output logic irq_slot15
);
    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [7:0] swap_reg; // Pin-swap control.
    logic [7:0] sel_reg; // Serial-select control.
    logic [7:0] rdata_reg; // Read data for the cycle after a read.
    logic [7:0] rdata_next; // Read data selected by address.
    logic swap_hit; // Address names the swap register.
    logic sel_hit; // Address names the select register.
    logic own_lo_hit; // Address names the low ownership status.
    logic own_hi_hit; // Address names the high ownership status.
    logic [SPR_NPINS-1:0] own_next; // Pins claimed by a serial function.

    assign swap_hit = (reg_addr == SPR_SWAP_ADDR);
    assign sel_hit = (reg_addr == SPR_SEL_ADDR);
    assign own_lo_hit = (reg_addr == SPR_OWN_LO_ADDR);
    assign own_hi_hit = (reg_addr == SPR_OWN_HI_ADDR);

    // Writes keep only the defined bits; software is expected to hold the
    // affected controllers idle while it changes them.
    always_ff @(posedge clk) begin
        if (rst) begin
            swap_reg <= SPR_SWAP_RESET;
            sel_reg <= SPR_SEL_RESET;
        end else if (reg_wr) begin
            if (swap_hit) begin
                swap_reg <= reg_wdata & SPR_SWAP_MASK;
            end
            if (sel_hit) begin
                sel_reg <= reg_wdata & SPR_SEL_MASK;
            end
        end
    end

    // Read mux; unmapped addresses read as zero.
    assign rdata_next = swap_hit ? swap_reg :
                        sel_hit ? sel_reg :
                        own_lo_hit ? own_next[SPR_LO_PINS-1:0] :
                        own_hi_hit ? {5'h00, own_next[SPR_NPINS-1:SPR_LO_PINS]} :
                        8'h00;

    // Read data stand for exactly one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;

    // ------------------------------------------------------------------
    // Decoded selection
    // ------------------------------------------------------------------
    logic [1:0] sel_code; // Serial-select field.
    logic bank; // Port-bank select bit.
    logic u0_swap; // UART0 swap bit.
    logic u1_swap; // UART1 swap bit.
    logic uart0_on; // UART0 is active.
    logic sio_hi; // SIO0 sits on P23-P25.
    logic sio_lo; // SIO0 sits on the selected bank.
    logic i2c_on; // I2C0 is active.
    logic [3:0] u0_tx_idx; // Pin carrying UART0 transmit.
    logic [3:0] u0_rx_idx; // Pin carrying UART0 receive.
    logic [3:0] u1_tx_idx; // Pin carrying UART1 transmit.
    logic [3:0] u1_rx_idx; // Pin carrying UART1 receive.
    logic [3:0] bank_base; // First pin of the selected bank.

    assign sel_code = sel_reg[SPR_SEL_LSB+1:SPR_SEL_LSB];
    assign bank = sel_reg[SPR_BANK_BIT];
    assign u0_swap = swap_reg[SPR_U0_SWAP_BIT];
    assign u1_swap = swap_reg[SPR_U1_SWAP_BIT];
    assign uart0_on = (sel_code == SPR_SEL_UART_I2C) || (sel_code == SPR_SEL_UART_SIO);
    assign sio_hi = (sel_code == SPR_SEL_UART_SIO);
    assign sio_lo = (sel_code == SPR_SEL_SIO_I2C);
    assign i2c_on = (sel_code == SPR_SEL_UART_I2C) || (sel_code == SPR_SEL_SIO_I2C);
    assign bank_base = bank ? SPR_PB4 : SPR_P20;
    assign u0_tx_idx = u0_swap ? bank_base + 4'h1 : bank_base;
    assign u0_rx_idx = u0_swap ? bank_base : bank_base + 4'h1;
    assign u1_tx_idx = u1_swap ? SPR_P91 : SPR_P90;
    assign u1_rx_idx = u1_swap ? SPR_P90 : SPR_P91;

    // ------------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------------
    logic [SPR_NPINS-1:0] pin_sync; // Filtered pin levels.

    for (genvar g = 0; g < SPR_NPINS; g++) begin : g_sync
        spr_pin_sync #(
            .RESET_VAL(1'b1)
        ) u_sync (
            .clk(clk),
            .rst(rst),
            .async_in(pin_in[g]),
            .sync_out(pin_sync[g])
        );
    end

    // ------------------------------------------------------------------
    // Pin routing matrix
    // ------------------------------------------------------------------
    logic [SPR_NPINS-1:0] out_next; // Next pin output levels.
    logic [SPR_NPINS-1:0] oe_next; // Next pin output enables.

    // Every pin starts as a port pin; serial functions then claim theirs.
    always_comb begin
        out_next = gpio_out;
        oe_next = gpio_oe;
        own_next = '0;
        // UART1 is always routed.
        out_next[u1_tx_idx] = uart1_transmit;
        oe_next[u1_tx_idx] = 1'b1;
        oe_next[u1_rx_idx] = 1'b0;
        own_next[SPR_P90] = 1'b1;
        own_next[SPR_P91] = 1'b1;
        if (uart0_on) begin
            out_next[u0_tx_idx] = uart0_transmit;
            oe_next[u0_tx_idx] = 1'b1;
            oe_next[u0_rx_idx] = 1'b0;
            own_next[u0_tx_idx] = 1'b1;
            own_next[u0_rx_idx] = 1'b1;
        end
        if (sio_lo) begin
            out_next[bank_base] = sync_serial_out;
            oe_next[bank_base] = 1'b1;
            oe_next[bank_base + 4'h1] = 1'b0;
            out_next[bank_base + 4'h2] = sync_serial_clock;
            oe_next[bank_base + 4'h2] = 1'b1;
            own_next[bank_base] = 1'b1;
            own_next[bank_base + 4'h1] = 1'b1;
            own_next[bank_base + 4'h2] = 1'b1;
        end
        if (sio_hi) begin
            out_next[SPR_P23] = sync_serial_out;
            oe_next[SPR_P23] = 1'b1;
            oe_next[SPR_P24] = 1'b0;
            out_next[SPR_P25] = sync_serial_clock;
            oe_next[SPR_P25] = 1'b1;
            own_next[SPR_P23] = 1'b1;
            own_next[SPR_P24] = 1'b1;
            own_next[SPR_P25] = 1'b1;
        end
        if (i2c_on) begin
            // Open-drain lines only ever pull low.
            out_next[SPR_P23] = 1'b0;
            oe_next[SPR_P23] = i2c_sda_pull_low;
            out_next[SPR_P24] = 1'b0;
            oe_next[SPR_P24] = i2c_scl_pull_low;
            own_next[SPR_P23] = 1'b1;
            own_next[SPR_P24] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Controller-side inputs
    // ------------------------------------------------------------------
    logic u0_rx_next; // UART0 receive, idle high when unrouted.
    logic si_next; // SIO0 input, low when unrouted.
    logic [3:0] si_idx; // Pin carrying SIO0 input.

    assign si_idx = sio_hi ? SPR_P24 : bank_base + 4'h1;
    assign u0_rx_next = uart0_on ? pin_sync[u0_rx_idx] : 1'b1;
    assign si_next = (sio_hi || sio_lo) ? pin_sync[si_idx] : 1'b0;

    // ------------------------------------------------------------------
    // Interrupt slot routing
    // ------------------------------------------------------------------
    logic slot7_next; // Slot 7 source.
    logic slot6_next; // Slot 6 source.
    logic slot15_next; // Slot 15 source.

    assign slot7_next = uart0_on & uart0_tx_interrupt;
    assign slot6_next = uart0_on ? uart0_rx_interrupt : (sio_lo & sync_serial_interrupt);
    assign slot15_next = sio_hi ? sync_serial_interrupt : (i2c_on & i2c_interrupt);

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    // All outputs leave through flip-flops, one cycle after their sources.
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out <= '0;
            pin_oe <= '0;
            pin_owned <= '0;
            gpio_in <= '0;
            uart0_receive <= 1'b1;
            uart1_receive <= 1'b1;
            sync_serial_in <= 1'b0;
            i2c_data_line <= 1'b1;
            i2c_clock_line <= 1'b1;
            irq_slot7 <= 1'b0;
            irq_slot6 <= 1'b0;
            irq_slot15 <= 1'b0;
        end else begin
            pin_out <= out_next;
            pin_oe <= oe_next;
            pin_owned <= own_next;
            gpio_in <= pin_sync & ~own_next;
            uart0_receive <= u0_rx_next;
            uart1_receive <= pin_sync[u1_rx_idx];
            sync_serial_in <= si_next;
            i2c_data_line <= i2c_on ? pin_sync[SPR_P23] : 1'b1;
            i2c_clock_line <= i2c_on ? pin_sync[SPR_P24] : 1'b1;
            irq_slot7 <= slot7_next;
            irq_slot6 <= slot6_next;
            irq_slot15 <= slot15_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_uart1_normal_pins: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && !$past(swap_reg[SPR_U1_SWAP_BIT])
        |-> pin_oe[SPR_P90] && !pin_oe[SPR_P91] && pin_out[SPR_P90] == $past(uart1_transmit))
        else $error("UART1 transmit not on P90 with swap clear");

    chk_uart1_swapped_pins: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $past(swap_reg[SPR_U1_SWAP_BIT])
        |-> pin_oe[SPR_P91] && !pin_oe[SPR_P90] && pin_out[SPR_P91] == $past(uart1_transmit))
        else $error("UART1 transmit not on P91 with swap set");

    chk_uart0_bank_pins: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $past(sel_reg) == {3'h0, 1'b1, 4'h0} && !$past(u0_swap)
        |-> pin_oe[SPR_PB4] && !pin_oe[SPR_PB5] && pin_out[SPR_PB4] == $past(uart0_transmit)
            && pin_owned[SPR_PB5] && !pin_owned[SPR_P20])
        else $error("UART0 not on PB4/PB5 for bank one");

    chk_unowned_gpio: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> ((pin_oe ^ $past(gpio_oe)) & ~pin_owned) == '0
            && ((pin_out ^ $past(gpio_out)) & ~pin_owned) == '0)
        else $error("Unassigned pin does not follow port logic");

    chk_reserved_code: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $past(sel_code) == 2'h3
        |-> pin_owned[SPR_P25:SPR_P20] == '0 && pin_owned[SPR_PB6:SPR_PB4] == '0
            && !irq_slot7 && !irq_slot6 && !irq_slot15)
        else $error("Reserved select code routes a function");

    chk_sio_slot_map: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $past(sel_code) == SPR_SEL_SIO_I2C
        |-> !irq_slot7 && irq_slot6 == $past(sync_serial_interrupt) && irq_slot15 == $past(i2c_interrupt))
        else $error("Slot map wrong for SIO0 with I2C0");

    chk_uart_slot_map: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $past(sel_code) == SPR_SEL_UART_SIO
        |-> irq_slot7 == $past(uart0_tx_interrupt) && irq_slot6 == $past(uart0_rx_interrupt)
            && irq_slot15 == $past(sync_serial_interrupt))
        else $error("Slot map wrong for UART0 with SIO0");

    chk_swap_readback: assert property (@(posedge clk) disable iff (rst)
        reg_rd && swap_hit && !reg_wr ##1 1'b1 |-> reg_rdata == {6'h00, $past(swap_reg[1:0])})
        else $error("Swap register readback wrong");

endmodule : spr_router

// ===== dv/spr_ctrl_model.sv
// Behavioural model of the serial controllers that face the router.
`timescale 1ns/10ps
module spr_ctrl_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [9:0] drive,
    output logic uart0_transmit,
    output logic uart1_transmit,
    output logic sync_serial_out,
    output logic sync_serial_clock,
    output logic i2c_sda_pull_low,
    output logic i2c_scl_pull_low,
    output logic uart0_tx_interrupt,
    output logic uart0_rx_interrupt,
    output logic sync_serial_interrupt,
    output logic i2c_interrupt
);
    // ------------------------------------------------------------------
    // Controller lines
    // ------------------------------------------------------------------
    // Stopped controllers hold transmit and clock high, release both pulls and raise no interrupt.
    localparam logic [9:0] IDLE = 10'h00f;
    logic [9:0] lines_reg;
    // Lines move only just after an edge, and drop to idle whenever the controllers are stopped.
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            lines_reg <= IDLE;
        end else begin
            lines_reg <= drive;
        end
    end
    assign {i2c_interrupt, sync_serial_interrupt, uart0_rx_interrupt, uart0_tx_interrupt, i2c_scl_pull_low,
            i2c_sda_pull_low, sync_serial_clock, sync_serial_out, uart1_transmit, uart0_transmit} = lines_reg;
endmodule : spr_ctrl_model

// ===== dv/testbench.sv
// Self-checking testbench for the serial pin and interrupt router.
`timescale 1ns/10ps
module testbench;
    import spr_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [10:0] pin_in, pin_out, pin_oe, gpio_in, pin_owned;
    logic [10:0] ext_lvl = 11'h7ff;
    logic [10:0] gpio_out = 11'h2b5;
    logic [10:0] gpio_oe = 11'h7ff;
    logic [10:0] pin_function_control = 11'h000;
    logic run = 1'b0;
    logic [9:0] drive = 10'h00f;
    logic uart0_transmit, uart1_transmit, sync_serial_out, sync_serial_clock, i2c_sda_pull_low;
    logic i2c_scl_pull_low, uart0_tx_interrupt, uart0_rx_interrupt, sync_serial_interrupt, i2c_interrupt;
    logic uart0_receive, uart1_receive, sync_serial_in, i2c_data_line, i2c_clock_line;
    logic irq_slot7, irq_slot6, irq_slot15;
    int n_errors = 0;
    int samples_checked = 0;
    always #2 clk = ~clk;
    // A driven pin shows its drive; an undriven one shows the outside level, pulled up by default.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
    spr_router spr_router_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out,
        .pin_oe, .gpio_out, .gpio_oe, .pin_function_control, .gpio_in, .pin_owned, .uart0_transmit, .uart0_receive,
        .uart1_transmit, .uart1_receive, .sync_serial_out, .sync_serial_in, .sync_serial_clock, .i2c_sda_pull_low,
        .i2c_scl_pull_low, .i2c_data_line, .i2c_clock_line, .uart0_tx_interrupt, .uart0_rx_interrupt,
        .sync_serial_interrupt, .i2c_interrupt, .irq_slot7, .irq_slot6, .irq_slot15);
    spr_ctrl_model spr_ctrl_model_i (.clk, .rst, .run, .drive, .uart0_transmit, .uart1_transmit, .sync_serial_out,
        .sync_serial_clock, .i2c_sda_pull_low, .i2c_scl_pull_low, .uart0_tx_interrupt, .uart0_rx_interrupt,
        .sync_serial_interrupt, .i2c_interrupt);
    // ------------------------------------------------------------------
    // Compare, bus and helper tasks
    // ------------------------------------------------------------------
    task automatic check_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_reg
    task automatic check_pins(input string what, input logic [10:0] exp, input logic [10:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_pins
    task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    // Read data stand only in the cycle after the strobe, so sample just after that edge.
    task automatic check_read(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check_reg("read data", exp, reg_rdata);
    endtask : check_read
    // Covers the one-cycle routing delay and the pin synchroniser.
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask : settle
    // Controllers are stopped around every routing change.
    task automatic route(input logic [7:0] swap, input logic [7:0] sel);
        @(posedge clk);
        run <= 1'b0;
        reg_write(SPR_SWAP_ADDR, swap);
        reg_write(SPR_SEL_ADDR, sel);
        settle();
        @(posedge clk);
        run <= 1'b1;
    endtask : route
    function automatic logic [10:0] own_exp(input int c, input int b);
        case (c)
            0: own_exp = b ? 11'h6d8 : 11'h61b;
            1: own_exp = b ? 11'h6f8 : 11'h63b;
            2: own_exp = b ? 11'h7d8 : 11'h61f;
            default: own_exp = 11'h600;
        endcase
    endfunction : own_exp
    // Bit 0 is slot 7, bit 1 slot 6, bit 2 slot 15; sources are transmit, receive, sync serial, i2c.
    function automatic logic [2:0] slot_exp(input int c, input int k);
        case ({c[1:0], k[1:0]})
            4'h0, 4'h4: slot_exp = 3'h1;
            4'h1, 4'h5, 4'ha: slot_exp = 3'h2;
            4'h3, 4'h6, 4'hb: slot_exp = 3'h4;
            default: slot_exp = 3'h0;
        endcase
    endfunction : slot_exp
    task automatic uart_probe(input int u, input int tx, input int rx, input logic [10:0] pair);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            drive <= 10'h00f ^ (10'(1 - v) << u);
            ext_lvl <= 11'h7ff ^ (11'(1 - v) << rx);
            settle();
            check_pins("transmit pin", 11'(v), 11'(pin_out[tx]));
            check_pins("pin enables", 11'h001 << tx, pin_oe & pair);
            check_pins("receive", 11'(v), 11'(u ? uart1_receive : uart0_receive));
        end
    endtask : uart_probe
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_registers();
        check_read(SPR_SWAP_ADDR, 8'h00);
        check_read(SPR_SEL_ADDR, 8'h00);
        reg_write(SPR_SWAP_ADDR, 8'hff);
        reg_write(12'hf00, 8'h00);
        check_read(SPR_SWAP_ADDR, 8'h03);
        check_read(12'hf00, 8'h00);
        reg_write(SPR_SEL_ADDR, 8'hff);
        check_read(SPR_SEL_ADDR, 8'h13);
        route(8'h00, 8'h00);
    endtask : test_registers
    task automatic test_select();
        logic [10:0] own;
        for (int c = 0; c < 4; c++) begin
            for (int b = 0; b < 2; b++) begin
                route(8'h00, 8'((b << 4) | c));
                own = own_exp(c, b);
                check_pins("pin_owned", own, pin_owned);
                check_pins("port drive", gpio_out & ~own, pin_out & ~own);
                check_pins("port enable", gpio_oe & ~own, pin_oe & ~own);
                check_pins("port input", gpio_out & ~own, gpio_in);
                check_read(SPR_OWN_LO_ADDR, own[7:0]);
                check_read(SPR_OWN_HI_ADDR, {5'h00, own[10:8]});
            end
        end
    endtask : test_select
    task automatic test_uart1();
        for (int s = 0; s < 2; s++) begin
            route(8'(s << 1), 8'h00);
            uart_probe(1, s ? 10 : 9, s ? 9 : 10, 11'h600);
        end
    endtask : test_uart1
    task automatic test_uart0();
        for (int b = 0; b < 2; b++) begin
            for (int s = 0; s < 2; s++) begin
                route(8'(s), 8'(b << 4));
                uart_probe(0, b * 6 + s, b * 6 + 1 - s, 11'h003 << (b * 6));
            end
        end
    endtask : test_uart0
    task automatic test_irq();
        for (int c = 0; c < 4; c++) begin
            route(8'h00, 8'(c));
            for (int k = 0; k < 4; k++) begin
                @(posedge clk);
                drive <= 10'h00f | (10'h040 << k);
                settle();
                check_pins("irq slots", 11'(slot_exp(c, k)), {8'h00, irq_slot15, irq_slot6, irq_slot7});
            end
        end
    endtask : test_irq
    // SIO0 on P23-P25 or on a bank, I2C0 open-drain on P23/P24; lines flip between two patterns.
    task automatic test_sio_i2c();
        int so;
        for (int c = 0; c < 3; c++) begin
            for (int b = 0; b < 2; b++) begin
                route(8'h00, 8'((b << 4) | c));
                so = (c == 1) ? 3 : b * 6;
                for (int v = 0; v < 2; v++) begin
                    @(posedge clk);
                    drive <= v ? 10'h027 : 10'h01b;
                    ext_lvl <= v ? 11'h7ff : ~(11'h001 << (so + 1));
                    settle();
                    if (c != 0) begin
                        check_pins("sio out and clock", 11'(2 * (1 - v) + v), 11'({pin_out[so + 2], pin_out[so]}));
                    end
                    check_pins("sync serial in", (c != 0) ? 11'(v) : 11'h000, 11'(sync_serial_in));
                    check_pins("i2c drive", (c != 1) ? 11'(1 + v) << 3 : 11'h008, pin_oe & 11'h018);
                    check_pins("i2c lines", (c != 1) ? 11'(2 * (1 - v) + v) : 11'h003,
                        11'({i2c_clock_line, i2c_data_line}));
                end
            end
        end
    endtask : test_sio_i2c
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    // Main sequence: reset for 20 cycles, then every scenario in turn.
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        test_registers();
        test_select();
        test_uart1();
        test_uart0();
        test_irq();
        test_sio_i2c();
        tally_and_finish();
    end
    // Watchdog: the scenarios need well under a tenth of this span.
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
endmodule : testbench
